// ---- tb/test_cpu_register_set.sv ----
`timescale 1ns/100ps
module test_cpu_register_set
	import cpu_regset_pkg::*;
;
	// ------------------------------------------------------------
	// stimulus and outputs
	// ------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] rd_a_idx = 4'h0, rd_b_idx = 4'h0, gpr_widx = 4'h0;
	logic gpr_we = 1'b0, vtb_we = 1'b0, fit_we = 1'b0, isp_we = 1'b0, usp_we = 1'b0, bpc_we = 1'b0, backup_status_word_we = 1'b0;
	logic pc_we = 1'b0, status_we = 1'b0, fast_irq_take = 1'b0, fast_irq_return = 1'b0;
	logic [31:0] gpr_wdata = 32'h0, ctl_wdata = 32'h0, pc_next = 32'h0, status_next = 32'h0, acc_wdata = 32'h0;
	logic [63:0] acc_result = 64'h0;
	acc_op_t acc_op = ACC_OP_NONE;
	logic [31:0] rd_a_data, rd_b_data, prog_counter, status_word, stack_ptr, interrupt_stack_ptr;
	logic [31:0] user_stack_ptr, vector_table_base, backup_prog_counter, backup_status_word, fast_irq_target;
	logic [31:0] acc_read_high, acc_read_middle;
	logic [63:0] accumulator_64;
	int n_mismatch = 0;
	int checks = 0;
	// reference state
	logic [31:0] m_gpr [16];
	logic [31:0] m_isp, m_usp, m_vtb, m_fit, m_bpc, m_backup_status_word, m_pc, m_st;
	logic [63:0] m_acc;

	always #10 clk_sys = ~clk_sys;

	cpu_register_set i_cpu_register_set (.clk_sys(clk_sys), .resetn(resetn), .rd_a_idx(rd_a_idx),
		.rd_b_idx(rd_b_idx), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .gpr_we(gpr_we),
		.gpr_widx(gpr_widx), .gpr_wdata(gpr_wdata), .vtb_we(vtb_we), .fit_we(fit_we), .isp_we(isp_we),
		.usp_we(usp_we), .bpc_we(bpc_we), .backup_status_word_we(backup_status_word_we), .ctl_wdata(ctl_wdata), .pc_we(pc_we),
		.pc_next(pc_next), .status_we(status_we), .status_next(status_next), .fast_irq_take(fast_irq_take),
		.fast_irq_return(fast_irq_return), .acc_op(acc_op), .acc_wdata(acc_wdata), .acc_result(acc_result),
		.prog_counter(prog_counter), .status_word(status_word), .stack_ptr(stack_ptr),
		.interrupt_stack_ptr(interrupt_stack_ptr), .user_stack_ptr(user_stack_ptr),
		.vector_table_base(vector_table_base), .backup_prog_counter(backup_prog_counter),
		.backup_status_word(backup_status_word), .fast_irq_target(fast_irq_target),
		.accumulator_64(accumulator_64), .acc_read_high(acc_read_high), .acc_read_middle(acc_read_middle));

	// ------------------------------------------------------------
	// expectation functions
	// ------------------------------------------------------------
	function automatic logic [63:0] acc_next(input logic [63:0] a, input acc_op_t op, input logic [31:0] w,
		input logic [63:0] r);
		case (op)
			ACC_OP_WRITE_HIGH: acc_next = {w, a[31:0]};
			ACC_OP_WRITE_LOW: acc_next = {a[63:32], w};
			ACC_OP_LOAD: acc_next = r;
			ACC_OP_ADD: acc_next = a + r;
			default: acc_next = a;
		endcase
	endfunction

	function automatic logic [31:0] sp_exp();
		sp_exp = m_st[STATUS_STACK_SEL_BIT] ? m_usp : m_isp;
	endfunction

	function automatic logic [31:0] rd_exp(input logic [3:0] i);
		rd_exp = (i == STACK_REG_IDX) ? sp_exp() : m_gpr[i];
	endfunction

	// ------------------------------------------------------------
	// reference model
	// ------------------------------------------------------------
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			foreach (m_gpr[i]) m_gpr[i] <= WORD_RESET;
			{m_isp, m_usp, m_vtb, m_fit, m_bpc, m_backup_status_word, m_pc, m_st} <= {8{WORD_RESET}};
			m_acc <= ACC_RESET;
		end else begin
			if (gpr_we && gpr_widx != STACK_REG_IDX) m_gpr[gpr_widx] <= gpr_wdata;
			if (gpr_we && gpr_widx == STACK_REG_IDX && !m_st[STATUS_STACK_SEL_BIT]) m_isp <= gpr_wdata;
			else if (isp_we) m_isp <= ctl_wdata;
			if (gpr_we && gpr_widx == STACK_REG_IDX && m_st[STATUS_STACK_SEL_BIT]) m_usp <= gpr_wdata;
			else if (usp_we) m_usp <= ctl_wdata;
			if (vtb_we) m_vtb <= ctl_wdata;
			if (fit_we) m_fit <= ctl_wdata;
			if (fast_irq_take) m_bpc <= m_pc;
			else if (bpc_we) m_bpc <= ctl_wdata;
			if (fast_irq_take) m_backup_status_word <= m_st;
			else if (backup_status_word_we) m_backup_status_word <= ctl_wdata;
			if (fast_irq_take) m_pc <= m_fit;
			else if (fast_irq_return) m_pc <= m_bpc;
			else if (pc_we) m_pc <= pc_next;
			if (fast_irq_return) m_st <= m_backup_status_word;
			else if (status_we) m_st <= status_next;
			m_acc <= acc_next(m_acc, acc_op, acc_wdata, acc_result);
		end
	end

	// ------------------------------------------------------------
	// comparisons
	// ------------------------------------------------------------
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp64(input logic [63:0] got, input logic [63:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	always @(negedge clk_sys) begin
		cmp32(rd_a_data, rd_exp(rd_a_idx), "read port a");
		cmp32(rd_b_data, rd_exp(rd_b_idx), "read port b");
		cmp32(stack_ptr, sp_exp(), "stack pointer");
		cmp32(interrupt_stack_ptr, m_isp, "interrupt stack");
		cmp32(user_stack_ptr, m_usp, "user stack");
		cmp32(vector_table_base, m_vtb, "vector base");
		cmp32(prog_counter, m_pc, "program counter");
		cmp32(status_word, m_st, "status word");
		cmp32(backup_prog_counter, m_bpc, "backup pc");
		cmp32(backup_status_word, m_backup_status_word, "backup status");
		cmp32(fast_irq_target, m_fit, "fast target");
		cmp64(accumulator_64, m_acc, "accumulator");
		cmp32(acc_read_high, m_acc[63:32], "acc high");
		cmp32(acc_read_middle, m_acc[47:16], "acc middle");
	end

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	task automatic drive_random();
		int r;
		logic [11:0] ix;
		r = $urandom % 8;
		ix = 12'($urandom);
		{rd_a_idx, rd_b_idx, gpr_widx} <= ix;
		{gpr_we, vtb_we, fit_we, pc_we, bpc_we, backup_status_word_we} <= 6'($urandom & $urandom);
		isp_we <= ($urandom % 4) == 0;
		usp_we <= ($urandom % 4) == 0;
		gpr_wdata <= (ix[3:0] == STACK_REG_IDX) ? ($urandom & 32'hFFFF_FFFC) : $urandom;
		ctl_wdata <= $urandom & 32'hFFFF_FFFC;
		pc_next <= $urandom;
		status_next <= $urandom;
		status_we <= (r != 0) && ($urandom % 3 == 0);
		fast_irq_take <= (r == 0);
		fast_irq_return <= (r == 1);
		acc_op <= acc_op_t'($urandom % 5);
		acc_wdata <= $urandom;
		acc_result <= {$urandom, $urandom};
	endtask

	// quiet inputs around a reset edge so no request lands on a reset cycle
	task automatic drive_idle();
		{gpr_we, vtb_we, fit_we, isp_we, usp_we, bpc_we, backup_status_word_we, pc_we, status_we} <= 9'h000;
		fast_irq_take <= 1'b0;
		fast_irq_return <= 1'b0;
		acc_op <= ACC_OP_NONE;
	endtask

	task automatic directed(input logic tk, input logic rt, input acc_op_t op, input logic [31:0] wd);
		@(posedge clk_sys);
		{gpr_we, vtb_we, fit_we, isp_we, usp_we, bpc_we, backup_status_word_we, pc_we, status_we} <= 9'h000;
		fast_irq_take <= tk;
		fast_irq_return <= rt;
		acc_op <= op;
		acc_wdata <= wd;
	endtask

	task automatic wrap_up();
		if (n_mismatch == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(79060));
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk_sys);
			if (i >= 1499 && i <= 1502) drive_idle();
			else drive_random();
			if (i == 1500) resetn <= 1'b0;
			if (i == 1502) resetn <= 1'b1;
		end
		directed(1'b1, 1'b0, ACC_OP_WRITE_HIGH, 32'hFFFF_FFFF);
		directed(1'b0, 1'b1, ACC_OP_WRITE_LOW, 32'h0000_0000);
		directed(1'b1, 1'b0, ACC_OP_WRITE_LOW, 32'hA5A5_5A5A);
		directed(1'b0, 1'b1, ACC_OP_NONE, 32'h0000_0000);
		repeat (3) @(posedge clk_sys);
		wrap_up();
	end
endmodule

// ---- verilog/accumulator_unit.sv ----
`timescale 1ns/100ps
module accumulator_unit
	import cpu_regset_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// operation
	input wire acc_op_t acc_op,
	input wire logic [WORD_W-1:0] acc_wdata,
	input wire logic [ACC_W-1:0] acc_result,
	// state
	output logic [ACC_W-1:0] accumulator_64,
	output logic [WORD_W-1:0] acc_read_high,
	output logic [WORD_W-1:0] acc_read_middle
);
	logic [ACC_W-1:0] acc_r;

	// ------------------------------------------------------------
	// accumulator storage
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			acc_r <= ACC_RESET;
		end else begin
			case (acc_op)
				ACC_OP_WRITE_HIGH: acc_r[ACC_W-1:ACC_HI_LSB] <= acc_wdata;
				ACC_OP_WRITE_LOW: acc_r[ACC_HI_LSB-1:0] <= acc_wdata;
				ACC_OP_LOAD: acc_r <= acc_result;
				ACC_OP_ADD: acc_r <= acc_r + acc_result;
				default: acc_r <= acc_r;
			endcase
		end
	end

	assign accumulator_64 = acc_r;
	assign acc_read_high = acc_r[ACC_HI_LSB +: WORD_W];
	assign acc_read_middle = acc_r[ACC_MID_LSB +: WORD_W];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_write_high;
		@(posedge clk_sys) disable iff (!resetn)
		acc_op == ACC_OP_WRITE_HIGH |=> acc_r[63:32] == $past(acc_wdata) && acc_r[31:0] == $past(acc_r[31:0]);
	endproperty
	a_write_high: assert property (p_write_high) else $error("high write wrong");
	property p_write_low;
		@(posedge clk_sys) disable iff (!resetn)
		acc_op == ACC_OP_WRITE_LOW |=> acc_r[31:0] == $past(acc_wdata) && acc_r[63:32] == $past(acc_r[63:32]);
	endproperty
	a_write_low: assert property (p_write_low) else $error("low write wrong");
	property p_acc_add;
		@(posedge clk_sys) disable iff (!resetn)
		acc_op == ACC_OP_ADD |=> acc_r == $past(acc_r) + $past(acc_result);
	endproperty
	a_acc_add: assert property (p_acc_add) else $error("accumulate wrong");
	property p_read_mid;
		@(posedge clk_sys) disable iff (!resetn)
		acc_op == ACC_OP_WRITE_LOW |=> acc_read_middle == {$past(acc_r[47:32]), $past(acc_wdata[31:16])};
	endproperty
	a_read_mid: assert property (p_read_mid) else $error("middle read wrong");
	c_acc_add: cover property (@(posedge clk_sys) acc_op == ACC_OP_ADD ##1 acc_op == ACC_OP_ADD);
endmodule

// ---- verilog/cpu_register_set.sv ----
// Behaviour
// - sixteen general registers, read by two ports, written by one
// - general register zero acts as the stack pointer
// - status stack select bit picks interrupt or user stack pointer
// - vector table base register holds relocatable vector table start
// - program counter holds address of executing instruction
// - status word updated from instruction results and processor state
// - fast interrupt copies program counter into backup program counter
// - fast interrupt copies status word into backup status word
// - fast interrupt branches to fast irq target register
// - a 64-bit accumulator is provided
// - multiply and multiply-accumulate instructions modify the accumulator
// - write-high loads bits 63:32, write-low bits 31:0, other half kept
// - read-high returns bits 63:32, read-middle bits 47:16
`timescale 1ns/100ps
module cpu_register_set
	import cpu_regset_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// general register access
	input wire logic [REG_IDX_W-1:0] rd_a_idx,
	input wire logic [REG_IDX_W-1:0] rd_b_idx,
	output logic [WORD_W-1:0] rd_a_data,
	output logic [WORD_W-1:0] rd_b_data,
	input wire logic gpr_we,
	input wire logic [REG_IDX_W-1:0] gpr_widx,
	input wire logic [WORD_W-1:0] gpr_wdata,
	// control register writes
	input wire logic vtb_we,
	input wire logic fit_we,
	input wire logic isp_we,
	input wire logic usp_we,
	input wire logic bpc_we,
	input wire logic backup_status_word_we,
	input wire logic [WORD_W-1:0] ctl_wdata,
	// program flow
	input wire logic pc_we,
	input wire logic [WORD_W-1:0] pc_next,
	input wire logic status_we,
	input wire logic [WORD_W-1:0] status_next,
	input wire logic fast_irq_take,
	input wire logic fast_irq_return,
	// accumulator
	input wire acc_op_t acc_op,
	input wire logic [WORD_W-1:0] acc_wdata,
	input wire logic [ACC_W-1:0] acc_result,
	// state
	output logic [WORD_W-1:0] prog_counter,
	output logic [WORD_W-1:0] status_word,
	output logic [WORD_W-1:0] stack_ptr,
	output logic [WORD_W-1:0] interrupt_stack_ptr,
	output logic [WORD_W-1:0] user_stack_ptr,
	output logic [WORD_W-1:0] vector_table_base,
	output logic [WORD_W-1:0] backup_prog_counter,
	output logic [WORD_W-1:0] backup_status_word,
	output logic [WORD_W-1:0] fast_irq_target,
	output logic [ACC_W-1:0] accumulator_64,
	output logic [WORD_W-1:0] acc_read_high,
	output logic [WORD_W-1:0] acc_read_middle
);
	logic [WORD_W-1:0] reg_view [NUM_REGS];
	logic [WORD_W-1:0] isp_r;
	logic [WORD_W-1:0] usp_r;
	logic [WORD_W-1:0] pc_r;
	logic [WORD_W-1:0] psw_r;
	logic [WORD_W-1:0] vtb_r;
	logic [WORD_W-1:0] bpc_r;
	logic [WORD_W-1:0] backup_status_word_r;
	logic [WORD_W-1:0] fit_r;
	logic user_mode;
	logic sp_write;

	generate
		if (STATUS_STACK_SEL_BIT >= WORD_W || NUM_REGS > 2 ** REG_IDX_W) begin : g_bad_cfg
			$error("register set configuration out of range");
		end
	endgenerate

	// ------------------------------------------------------------
	// stack pointer banking
	// ------------------------------------------------------------
	assign user_mode = psw_r[STATUS_STACK_SEL_BIT];
	assign sp_write = gpr_we && gpr_widx == STACK_REG_IDX;
	assign stack_ptr = user_mode ? usp_r : isp_r;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			isp_r <= WORD_RESET;
		end else if (sp_write && !user_mode) begin
			isp_r <= gpr_wdata;
		end else if (isp_we) begin
			isp_r <= ctl_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			usp_r <= WORD_RESET;
		end else if (sp_write && user_mode) begin
			usp_r <= gpr_wdata;
		end else if (usp_we) begin
			usp_r <= ctl_wdata;
		end
	end

	// ------------------------------------------------------------
	// general registers
	// ------------------------------------------------------------
	// each word lives in its own generate scope, the stack slot is a view of the banked pointer
	generate
		for (genvar i = 0; i < NUM_REGS; i++) begin : g_gen
			if (i == STACK_REG_IDX) begin : g_sp
				assign reg_view[i] = stack_ptr;
			end else begin : g_word
				logic [WORD_W-1:0] word_r;
				always_ff @(posedge clk_sys or negedge resetn) begin
					if (!resetn) begin
						word_r <= WORD_RESET;
					end else if (gpr_we && gpr_widx == REG_IDX_W'(i)) begin
						word_r <= gpr_wdata;
					end
				end
				assign reg_view[i] = word_r;
			end
		end
	endgenerate
	assign rd_a_data = reg_view[rd_a_idx];
	assign rd_b_data = reg_view[rd_b_idx];

	// ------------------------------------------------------------
	// program counter and status word
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pc_r <= WORD_RESET;
		end else if (fast_irq_take) begin
			pc_r <= fit_r;
		end else if (fast_irq_return) begin
			pc_r <= bpc_r;
		end else if (pc_we) begin
			pc_r <= pc_next;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			psw_r <= WORD_RESET;
		end else if (fast_irq_return) begin
			psw_r <= backup_status_word_r;
		end else if (status_we) begin
			psw_r <= status_next;
		end
	end

	// ------------------------------------------------------------
	// backup and vector registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bpc_r <= WORD_RESET;
			backup_status_word_r <= WORD_RESET;
		end else if (fast_irq_take) begin
			bpc_r <= pc_r;
			backup_status_word_r <= psw_r;
		end else begin
			if (bpc_we) begin
				bpc_r <= ctl_wdata;
			end
			if (backup_status_word_we) begin
				backup_status_word_r <= ctl_wdata;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			vtb_r <= WORD_RESET;
			fit_r <= WORD_RESET;
		end else begin
			if (vtb_we) begin
				vtb_r <= ctl_wdata;
			end
			if (fit_we) begin
				fit_r <= ctl_wdata;
			end
		end
	end

	assign prog_counter = pc_r;
	assign status_word = psw_r;
	assign interrupt_stack_ptr = isp_r;
	assign user_stack_ptr = usp_r;
	assign vector_table_base = vtb_r;
	assign backup_prog_counter = bpc_r;
	assign backup_status_word = backup_status_word_r;
	assign fast_irq_target = fit_r;

	// ------------------------------------------------------------
	// accumulator
	// ------------------------------------------------------------
	accumulator_unit i_accumulator_unit (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.acc_op(acc_op),
		.acc_wdata(acc_wdata),
		.acc_result(acc_result),
		.accumulator_64(accumulator_64),
		.acc_read_high(acc_read_high),
		.acc_read_middle(acc_read_middle)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_sp_select;
		@(posedge clk_sys) disable iff (!resetn)
		status_we && !fast_irq_return && !sp_write && !isp_we && !usp_we ##1 rd_a_idx == STACK_REG_IDX
			|-> rd_a_data == ($past(status_next[STATUS_STACK_SEL_BIT]) ? $past(usp_r) : $past(isp_r));
	endproperty
	a_sp_select: assert property (p_sp_select) else $error("stack pointer select wrong");
	property p_sp_write;
		@(posedge clk_sys) disable iff (!resetn)
		sp_write && !user_mode && !usp_we |=> isp_r == $past(gpr_wdata) && usp_r == $past(usp_r);
	endproperty
	a_sp_write: assert property (p_sp_write) else $error("stack write wrong");
	property p_gpr_write;
		@(posedge clk_sys) disable iff (!resetn)
		gpr_we && gpr_widx != STACK_REG_IDX ##1 rd_b_idx == $past(gpr_widx) |-> rd_b_data == $past(gpr_wdata);
	endproperty
	a_gpr_write: assert property (p_gpr_write) else $error("general write lost");
	property p_fast_take;
		@(posedge clk_sys) disable iff (!resetn)
		fast_irq_take |=> bpc_r == $past(pc_r) && backup_status_word_r == $past(psw_r) && pc_r == $past(fit_r);
	endproperty
	a_fast_take: assert property (p_fast_take) else $error("fast interrupt entry wrong");
	property p_fast_ret;
		@(posedge clk_sys) disable iff (!resetn)
		fast_irq_return && !fast_irq_take |=> pc_r == $past(bpc_r) && psw_r == $past(backup_status_word_r);
	endproperty
	a_fast_ret: assert property (p_fast_ret) else $error("fast return wrong");
	property p_pc_step;
		@(posedge clk_sys) disable iff (!resetn)
		pc_we && !fast_irq_take && !fast_irq_return |=> pc_r == $past(pc_next);
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("program counter not updated");
	property p_status;
		@(posedge clk_sys) disable iff (!resetn)
		status_we && !fast_irq_return |=> psw_r == $past(status_next);
	endproperty
	a_status: assert property (p_status) else $error("status not updated");
	property p_vtb;
		@(posedge clk_sys) disable iff (!resetn)
		vtb_we ##1 !vtb_we |-> vector_table_base == $past(ctl_wdata, 1) ##1 vector_table_base == $past(vector_table_base);
	endproperty
	a_vtb: assert property (p_vtb) else $error("vector base wrong");
	c_fast_round: cover property (@(posedge clk_sys) fast_irq_take ##[1:8] fast_irq_return);
	c_user_sp: cover property (@(posedge clk_sys) user_mode && sp_write);
	c_isp_sp: cover property (@(posedge clk_sys) !user_mode && sp_write);
endmodule

// ---- verilog/cpu_regset_pkg.sv ----
package cpu_regset_pkg;
	// ------------------------------------------------------------
	// widths and layout
	// ------------------------------------------------------------
	localparam int WORD_W = 32;
	localparam int ACC_W = 64;
	localparam int NUM_REGS = 16;
	localparam int REG_IDX_W = 4;
	localparam logic [REG_IDX_W-1:0] STACK_REG_IDX = 4'h0;
	localparam int STATUS_STACK_SEL_BIT = 17;
	localparam int ACC_HI_LSB = 32;
	localparam int ACC_MID_LSB = 16;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
	localparam logic [ACC_W-1:0] ACC_RESET = 64'h0000_0000_0000_0000;
	// ------------------------------------------------------------
	// accumulator operations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ACC_OP_NONE,
		ACC_OP_WRITE_HIGH,
		ACC_OP_WRITE_LOW,
		ACC_OP_LOAD,
		ACC_OP_ADD
	} acc_op_t;
endpackage
